//--- verilog/pll_synth_divider_core.sv
`default_nettype none

module pll_synth_divider_core #(
	parameter int LOCK_RUNS = pll_core_pkg::LOCK_RUNS_DEF
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic sclk,
	input  wire logic serial_data,
	input  wire logic load_strobe,
	input  wire logic vco_input,
	input  wire logic xtal_input,
	output logic      divided_vco_clock,
	output logic      divided_ref_clock,
	output logic      pump_up,
	output logic      pump_down,
	output logic      lock_flag_out,
	output logic      drain_out,
	output logic      drain_oe_n,
	output logic      standby_out
);
	import pll_core_pkg::*;

	generate
		if (LOCK_RUNS < 1 || LOCK_RUNS >= int'(GOOD_MAX)) begin : g_bad
			$error("LOCK_RUNS out of range");
		end
	endgenerate

	localparam logic [GOOD_W-1:0] RUNS = GOOD_W'(LOCK_RUNS);

	function automatic logic sel_input(input logic [1:0] sel);
		return ~sel[SEL2_POS];
	endfunction : sel_input

	logic [PIN_N-1:0]  pin_lvl;
	logic [PIN_N-1:0]  pin_rise;
	logic [WORD_W-1:0] shift_word;
	logic              load_ev;
	logic              vco_ev;
	logic              xtal_ev;
	logic [1:0]        sel;

	// Strobe, VCO and crystal are all foreign to mclk
	pin_sync #(
		.WIDTH (PIN_N)
	) u_sync (
		.mclk  (mclk),
		.rst   (rst),
		.pins  ({load_strobe, xtal_input, vco_input}),
		.level (pin_lvl),
		.rise  (pin_rise)
	);

	serial_shifter u_shift (
		.sclk        (sclk),
		.rst         (rst),
		.serial_data (serial_data),
		.word        (shift_word)
	);

	// Word is quiet while strobe is high, so it is safe to sample
	assign load_ev = pin_rise[PIN_LOAD];
	assign vco_ev  = pin_rise[PIN_VCO];
	assign xtal_ev = pin_rise[PIN_XTAL];
	assign sel     = shift_word[1:0];

	logic [IN_DIV_W-1:0]  in_div_r;
	logic [REF_DIV_W-1:0] ref_div_r;
	logic                 lock_out_enable_bit_r;
	logic                 test_bit_two_r;
	logic                 test_bit_three_r;
	logic                 standby_bit_r;
	logic                 drain_output_bit_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			in_div_r              <= IN_DIV_RST;
			ref_div_r             <= REF_DIV_RST;
			lock_out_enable_bit_r <= 1'b1;
			test_bit_two_r        <= 1'b0;
			test_bit_three_r      <= 1'b0;
			standby_bit_r         <= 1'b0;
			drain_output_bit_r    <= 1'b0;
		end else if (load_ev) begin
			if (sel_input(sel)) begin
				in_div_r <= shift_word[WORD_W-1:IN_DIV_LSB];
			end else if (sel == SEL_REF) begin
				ref_div_r <= shift_word[REF_DIV_LSB+REF_DIV_W-1:REF_DIV_LSB];
				lock_out_enable_bit_r <= shift_word[LOCK_EN_POS];
				test_bit_two_r        <= shift_word[TEST2_POS];
				test_bit_three_r      <= shift_word[TEST3_POS];
			end else begin
				standby_bit_r      <= shift_word[STANDBY_POS];
				drain_output_bit_r <= shift_word[DRAIN_POS];
			end
		end
	end

	// Input divider
	logic [PRE_W-1:0]     pre_cnt_r;
	logic [PRE_W-1:0]     pre_last;
	logic [SWALLOW_W-1:0] swallow_left_r;
	logic [MAIN_W-1:0]    main_left_r;
	logic                 vco_tick_r;

	assign pre_last = (swallow_left_r != '0) ? PRE_HIGH_LAST : PRE_LOW_LAST;

	// New ratios take effect at the next reload, never mid-cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pre_cnt_r      <= '0;
			swallow_left_r <= IN_DIV_RST[SWALLOW_W-1:0];
			main_left_r    <= IN_DIV_RST[IN_DIV_W-1:SWALLOW_W];
			vco_tick_r     <= 1'b0;
		end else if (standby_bit_r) begin
			pre_cnt_r      <= '0;
			swallow_left_r <= in_div_r[SWALLOW_W-1:0];
			main_left_r    <= in_div_r[IN_DIV_W-1:SWALLOW_W];
			vco_tick_r     <= 1'b0;
		end else begin
			vco_tick_r <= 1'b0;
			if (vco_ev) begin
				if (pre_cnt_r == pre_last) begin
					pre_cnt_r <= '0;
					if (main_left_r <= MAIN_W'(1)) begin
						swallow_left_r <= in_div_r[SWALLOW_W-1:0];
						main_left_r    <= in_div_r[IN_DIV_W-1:SWALLOW_W];
						vco_tick_r     <= 1'b1;
					end else begin
						main_left_r <= main_left_r - MAIN_W'(1);
						if (swallow_left_r != '0) begin
							swallow_left_r <= swallow_left_r - SWALLOW_W'(1);
						end
					end
				end else begin
					pre_cnt_r <= pre_cnt_r + PRE_W'(1);
				end
			end
		end
	end

	// Reference divider
	logic [REF_PRE_W-1:0] ref_pre_r;
	logic [REF_DIV_W-1:0] ref_left_r;
	logic                 ref_tick_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ref_pre_r  <= '0;
			ref_left_r <= REF_DIV_RST;
			ref_tick_r <= 1'b0;
		end else if (standby_bit_r) begin
			ref_pre_r  <= '0;
			ref_left_r <= ref_div_r;
			ref_tick_r <= 1'b0;
		end else begin
			ref_tick_r <= 1'b0;
			if (xtal_ev) begin
				ref_pre_r <= ref_pre_r + REF_PRE_W'(1);
				if (ref_pre_r == REF_PRE_LAST) begin
					if (ref_left_r <= REF_DIV_W'(1)) begin
						ref_left_r <= ref_div_r;
						ref_tick_r <= 1'b1;
					end else begin
						ref_left_r <= ref_left_r - REF_DIV_W'(1);
					end
				end
			end
		end
	end

	// Phase detector
	pfd_state_type    pfd_r;
	pfd_state_type    pfd_nxt;
	logic [ERR_W-1:0] err_cnt_r;
	logic [ERR_W-1:0] err_cnt_nxt;
	logic             cmp_done;
	logic             cmp_good;

	always_comb begin
		pfd_nxt     = pfd_r;
		err_cnt_nxt = err_cnt_r;
		cmp_done    = 1'b0;
		cmp_good    = 1'b0;
		if (pfd_r != PFD_IDLE && xtal_ev && err_cnt_r != ERR_MAX) begin
			err_cnt_nxt = err_cnt_r + ERR_W'(1);
		end
		unique case (pfd_r)
			PFD_IDLE: begin
				err_cnt_nxt = '0;
				if (ref_tick_r && vco_tick_r) begin
					cmp_done = 1'b1;
					cmp_good = 1'b1;
				end else if (ref_tick_r) begin
					pfd_nxt = PFD_UP;
				end else if (vco_tick_r) begin
					pfd_nxt = PFD_DOWN;
				end
			end
			PFD_UP: begin
				if (vco_tick_r) begin
					pfd_nxt  = PFD_IDLE;
					cmp_done = 1'b1;
					cmp_good = err_cnt_r < LOCK_WINDOW;
				end
			end
			PFD_DOWN: begin
				if (ref_tick_r) begin
					pfd_nxt  = PFD_IDLE;
					cmp_done = 1'b1;
					cmp_good = err_cnt_r < LOCK_WINDOW;
				end
			end
			default: pfd_nxt = PFD_IDLE;
		endcase
		if (standby_bit_r) begin
			pfd_nxt = PFD_IDLE;
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pfd_r     <= PFD_IDLE;
			err_cnt_r <= '0;
		end else begin
			pfd_r     <= pfd_nxt;
			err_cnt_r <= err_cnt_nxt;
		end
	end

	// Lock detection
	logic [GOOD_W-1:0] good_cnt_r;
	logic              locked_r;
	logic              err_big;

	// Wide error counts as unlocked before the comparison ends
	assign err_big = pfd_r != PFD_IDLE && err_cnt_r >= LOCK_WINDOW;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			good_cnt_r <= '0;
			locked_r   <= 1'b0;
		end else if (standby_bit_r || err_big) begin
			good_cnt_r <= '0;
			locked_r   <= 1'b0;
		end else if (cmp_done) begin
			if (cmp_good) begin
				if (good_cnt_r != GOOD_MAX) begin
					good_cnt_r <= good_cnt_r + GOOD_W'(1);
				end
				if (good_cnt_r >= RUNS) begin
					locked_r <= 1'b1;
				end
			end else begin
				good_cnt_r <= '0;
				locked_r   <= 1'b0;
			end
		end
	end

	// Output flops
	logic pump_up_r;
	logic pump_down_r;
	logic lock_flag_r;
	logic drain_oe_n_r;
	logic drain_out_r;
	logic standby_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pump_up_r   <= 1'b0;
			pump_down_r <= 1'b0;
		end else begin
			pump_up_r   <= pfd_nxt == PFD_UP;
			pump_down_r <= pfd_nxt == PFD_DOWN;
		end
	end

	// Disable beats standby so a cleared enable always reads low
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lock_flag_r <= 1'b0;
		end else if (!lock_out_enable_bit_r) begin
			lock_flag_r <= 1'b0;
		end else begin
			lock_flag_r <= standby_bit_r | locked_r;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			drain_oe_n_r <= 1'b1;
			drain_out_r  <= 1'b0;
			standby_r    <= 1'b0;
		end else begin
			drain_oe_n_r <= ~drain_output_bit_r;
			drain_out_r  <= 1'b0;
			standby_r    <= standby_bit_r;
		end
	end

	assign divided_vco_clock = vco_tick_r;
	assign divided_ref_clock = ref_tick_r;
	assign pump_up           = pump_up_r;
	assign pump_down         = pump_down_r;
	assign lock_flag_out     = lock_flag_r;
	assign drain_out         = drain_out_r;
	assign drain_oe_n        = drain_oe_n_r;
	assign standby_out       = standby_r;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_input_load: assert property (load_ev && sel_input(sel) |=>
		in_div_r == $past(shift_word[WORD_W-1:IN_DIV_LSB]))
		else $error("input latch not loaded");

	a_ref_load: assert property (load_ev && sel == SEL_REF |=>
		ref_div_r == $past(shift_word[REF_DIV_LSB+REF_DIV_W-1:REF_DIV_LSB])
		&& lock_out_enable_bit_r == $past(shift_word[LOCK_EN_POS]))
		else $error("reference latch not loaded");

	a_ctrl_load: assert property (load_ev && sel == SEL_CTRL |=>
		standby_bit_r == $past(shift_word[STANDBY_POS])
		&& drain_output_bit_r == $past(shift_word[DRAIN_POS]))
		else $error("control latch not loaded");

	a_lock_disable: assert property (!lock_out_enable_bit_r |=>
		!lock_flag_out)
		else $error("lock flag high while disabled");

	a_standby_lock: assert property (standby_bit_r &&
		lock_out_enable_bit_r ##1 lock_out_enable_bit_r |-> lock_flag_out)
		else $error("lock flag low in standby");

	a_pump_exclusive: assert property (!(pump_up && pump_down))
		else $error("both pump outputs active");

	a_drain_follow: assert property ($changed(drain_output_bit_r) |=>
		drain_oe_n == !$past(drain_output_bit_r) ##1 drain_oe_n == !drain_output_bit_r)
		else $error("drain output does not follow bit");

	a_prescale_range: assert property (pre_cnt_r <= PRE_HIGH_LAST &&
		(swallow_left_r != '0 || pre_cnt_r <= PRE_LOW_LAST))
		else $error("prescaler past its modulus");

	a_vco_reload: assert property (vco_tick_r |->
		main_left_r == in_div_r[IN_DIV_W-1:SWALLOW_W]
		&& swallow_left_r == in_div_r[SWALLOW_W-1:0])
		else $error("input counters not reloaded");

	a_ref_prescale: assert property (ref_tick_r |-> ref_pre_r == '0)
		else $error("reference tick off prescaler boundary");

	a_lock_after_runs: assert property ($rose(locked_r) |->
		good_cnt_r > RUNS && $past(cmp_good))
		else $error("lock declared too early");

	a_standby_quiet: assert property (standby_bit_r |=>
		!vco_tick_r && !ref_tick_r)
		else $error("dividers run in standby");

	c_load_ref: cover property (load_ev && sel == SEL_REF);
	c_load_ctrl: cover property (load_ev && sel == SEL_CTRL);
	c_lock_rise: cover property ($rose(lock_flag_out));
	c_pump_up: cover property ($rose(pump_up) ##[1:200] $fell(pump_up));

endmodule : pll_synth_divider_core

`default_nettype wire

//--- pkg/pll_core_pkg.sv
// Notes on behaviour
// - VCO passes a 64/65 prescaler, then 6-bit swallow and 12-bit main counters.
// - Total input ratio is 64 times main plus swallow; main not below swallow.
// - Low 6 divisor bits are swallow, upper 12 bits are main count.
// - Crystal passes fixed divide-by-eight, then a 13-bit reference counter.
// - Words are 20 bits over serial clock, serial data and load strobe.
// - Data shifts in on rising serial clock edges, most significant first.
// - Strobe rising copies the word into the latch named by last two bits.
// - Second select bit low loads the 18 divisor bits into input latch.
// - Both select bits high load 13 reference bits plus 3 test bits.
// - First test bit low forces the lock flag output low.
// - Select bits low then high load the standby and drain bits.
// - Standby bit low runs normally; standby bit high enters standby.
// - Phase detector compares divided clocks and drives pump error outputs.
// - Lock flag low on phase error, high when locked and in standby.
// - Lock declared after more than three comparisons under two crystal periods.
// - Open-drain output follows the programmed drain bit.
`default_nettype none

package pll_core_pkg;

	localparam int WORD_W    = 20;
	localparam int IN_DIV_W  = 18;
	localparam int SWALLOW_W = 6;
	localparam int MAIN_W    = 12;
	localparam int REF_DIV_W = 13;
	localparam int PRE_W     = 7;
	localparam int REF_PRE_W = 3;
	localparam int ERR_W     = 2;
	localparam int GOOD_W    = 3;

	localparam logic [PRE_W-1:0]     PRE_LOW_LAST  = 7'h3F;
	localparam logic [PRE_W-1:0]     PRE_HIGH_LAST = 7'h40;
	localparam logic [REF_PRE_W-1:0] REF_PRE_LAST  = 3'h7;

	localparam int IN_DIV_LSB   = 2;
	localparam int REF_DIV_LSB  = 5;
	localparam int LOCK_EN_POS  = 4;
	localparam int TEST2_POS    = 3;
	localparam int TEST3_POS    = 2;
	localparam int STANDBY_POS  = 19;
	localparam int DRAIN_POS    = 18;
	localparam int SEL2_POS     = 0;

	localparam logic [1:0] SEL_CTRL = 2'h1;
	localparam logic [1:0] SEL_REF  = 2'h3;

	localparam logic [IN_DIV_W-1:0]  IN_DIV_RST  = 18'h00FC0;
	localparam logic [REF_DIV_W-1:0] REF_DIV_RST = 13'h0005;

	localparam logic [ERR_W-1:0]  LOCK_WINDOW   = 2'h2;
	localparam logic [ERR_W-1:0]  ERR_MAX       = 2'h3;
	localparam logic [GOOD_W-1:0] GOOD_MAX      = 3'h7;
	localparam int                LOCK_RUNS_DEF = 3;

	localparam int PIN_VCO  = 0;
	localparam int PIN_XTAL = 1;
	localparam int PIN_LOAD = 2;
	localparam int PIN_N    = 3;

	typedef enum logic [1:0] {PFD_IDLE, PFD_UP, PFD_DOWN} pfd_state_type;

endpackage : pll_core_pkg

`default_nettype wire

//--- verilog/pin_sync.sv
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] level_r;
	logic [WIDTH-1:0] rise_r;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// Change counts only once stages two and three agree
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					s1_r[i]    <= 1'b0;
					s2_r[i]    <= 1'b0;
					s3_r[i]    <= 1'b0;
					level_r[i] <= 1'b0;
					rise_r[i]  <= 1'b0;
				end else begin
					s1_r[i]    <= pins[i];
					s2_r[i]    <= s1_r[i];
					s3_r[i]    <= s2_r[i];
					rise_r[i]  <= 1'b0;
					if (s2_r[i] == s3_r[i]) begin
						level_r[i] <= s3_r[i];
						rise_r[i]  <= s3_r[i] & ~level_r[i];
					end
				end
			end
		end
	endgenerate

	assign level = level_r;
	assign rise  = rise_r;

endmodule : pin_sync

`default_nettype wire

//--- verilog/serial_shifter.sv
`default_nettype none

module serial_shifter (
	input  wire logic                           sclk,
	input  wire logic                           rst,
	input  wire logic                           serial_data,
	output logic      [pll_core_pkg::WORD_W-1:0] word
);
	import pll_core_pkg::*;

	logic [WORD_W-1:0] word_r;

	// Most significant bit enters first and ends on top
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			word_r <= '0;
		end else begin
			word_r <= {word_r[WORD_W-2:0], serial_data};
		end
	end

	assign word = word_r;

endmodule : serial_shifter

`default_nettype wire

//--- tb/serial_loader_model.sv
`default_nettype none

module serial_loader_model (
	output logic sclk,
	output logic serial_data,
	output logic load_strobe
);
	timeunit 1ns;
	timeprecision 100ps;
	import pll_core_pkg::*;

	initial begin
		sclk        = 1'b0;
		serial_data = 1'b1;
		load_strobe = 1'b0;
	end

	// Link clock runs only inside a frame, at a fixed 30 ns period
	task automatic send_word(input logic [WORD_W-1:0] w, input int pace);
		for (int i = WORD_W - 1; i >= 0; i--) begin
			serial_data = w[i];
			#15;
			sclk = 1'b1;
			#15;
			sclk = 1'b0;
		end
		// Random pace only widens the gap before the strobe
		#(15 + pace);
		load_strobe = 1'b1;
		// Clock kept still well past the cross-domain capture window
		#100;
		load_strobe = 1'b0;
		serial_data = ~w[0];
		#60;
	endtask : send_word

endmodule : serial_loader_model

`default_nettype wire

//--- tb/test_pll_synth_divider_core.sv
`default_nettype none

module test_pll_synth_divider_core;
	timeunit 1ns;
	timeprecision 100ps;
	import pll_core_pkg::*;

	localparam int LIMIT = 20000;

	logic       mclk       = 1'b0;
	logic       rst        = 1'b1;
	logic       vco_input  = 1'b0;
	logic       xtal_input = 1'b0;
	logic [1:0] phase      = 2'h0;
	logic       sclk;
	logic       serial_data;
	logic       load_strobe;
	logic       divided_vco_clock;
	logic       divided_ref_clock;
	logic       pump_up;
	logic       pump_down;
	logic       lock_flag_out;
	logic       drain_out;
	logic       drain_oe_n;
	logic       standby_out;
	int         failures   = 0;
	int         num_checks = 0;
	int         m_n        = 4032;
	int         m_r        = 5;
	int         m_en       = 1;
	int         m_sb       = 0;
	int         m_dr       = 0;

	initial begin
		forever #4 mclk = ~mclk;
	end

	// Same phase on both pins so matched dividers tick together
	always @(posedge mclk) begin
		phase      <= phase + 2'h1;
		vco_input  <= phase[1];
		xtal_input <= phase[1];
	end

	pll_synth_divider_core #(.LOCK_RUNS(3)) i_pll_synth_divider_core (
		.mclk              (mclk),
		.rst               (rst),
		.sclk              (sclk),
		.serial_data       (serial_data),
		.load_strobe       (load_strobe),
		.vco_input         (vco_input),
		.xtal_input        (xtal_input),
		.divided_vco_clock (divided_vco_clock),
		.divided_ref_clock (divided_ref_clock),
		.pump_up           (pump_up),
		.pump_down         (pump_down),
		.lock_flag_out     (lock_flag_out),
		.drain_out         (drain_out),
		.drain_oe_n        (drain_oe_n),
		.standby_out       (standby_out)
	);

	serial_loader_model i_serial_loader_model (
		.sclk        (sclk),
		.serial_data (serial_data),
		.load_strobe (load_strobe)
	);

	task automatic final_report();
		$display("Checks %0d, failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	task automatic check_bit(input string what, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %b seen %b", what, e, g);
		end
	endtask : check_bit

	task automatic check_num(input string what, input int e, input int g);
		num_checks++;
		if (g != e) begin
			failures++;
			$display("BAD %s expected %0d seen %0d", what, e, g);
		end
	endtask : check_num

	task automatic tick();
		@(posedge mclk);
		#1;
	endtask : tick

	function automatic logic pick(input bit use_ref);
		return use_ref ? divided_ref_clock : divided_vco_clock;
	endfunction : pick

	// Ticks until the next divider pulse, bounded
	task automatic waitp(input bit use_ref, output int n);
		n = 0;
		do begin
			tick();
			n++;
		end while (pick(use_ref) !== 1'b1 && n < LIMIT);
		if (n >= LIMIT) begin
			failures++;
			final_report();
		end
	endtask : waitp

	// Input, reference and control latch decode, independent of the design
	function automatic void apply_word(input logic [WORD_W-1:0] w);
		if (w[0] == 1'b0) begin
			m_n = int'(w[19:2]);
		end else if (w[1] == 1'b1) begin
			m_r  = int'(w[17:5]);
			m_en = int'(w[4]);
		end else begin
			m_sb = int'(w[19]);
			m_dr = int'(w[18]);
		end
	endfunction : apply_word

	task automatic load(input logic [WORD_W-1:0] w);
		i_serial_loader_model.send_word(w, int'($urandom % 2) * 20);
		apply_word(w);
		repeat (8) tick();
	endtask : load

	initial begin
		int n;
		int k;
		logic [WORD_W-1:0] w;
		void'($urandom(37));
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		tick();
		check_bit("standby_out", 1'b0, standby_out);
		check_bit("drain_oe_n", 1'b1, drain_oe_n);
		check_bit("lock_flag_out", 1'b0, lock_flag_out);
		waitp(1'b1, n);
		waitp(1'b1, n);
		check_num("ref period", 32 * m_r, n);
		k = 5 + int'($urandom % 16);
		load({2'h3, 13'(k), 1'b1, 2'h0, 2'h3});
		waitp(1'b1, n);
		waitp(1'b1, n);
		check_num("ref period", 32 * m_r, n);
		tick();
		tick();
		check_bit("pump_up", 1'b1, pump_up);
		check_bit("pump_down", 1'b0, pump_down);
		for (int i = 0; i < 4; i++) begin
			w = {i[0], i[1], 16'($urandom), 2'h1};
			load(w);
			check_bit("standby_out", 1'(m_sb), standby_out);
			check_bit("drain_oe_n", ~1'(m_dr), drain_oe_n);
			check_bit("drain_out", 1'b0, drain_out);
			check_bit("lock_flag_out", 1'(m_sb), lock_flag_out);
		end
		// Dividers restart together when standby ends
		// Nonzero swallow so both prescaler moduli are used
		k = 1 + int'($urandom % 7);
		load({18'(4032 + 8 * k), 1'($urandom), 1'b0});
		load({2'h0, 13'(504 + k), 1'b1, 2'h0, 2'h3});
		load({2'h0, 16'h0000, 2'h1});
		repeat (3) waitp(1'b0, n);
		repeat (6) tick();
		check_bit("lock_flag_out", 1'b0, lock_flag_out);
		waitp(1'b0, n);
		check_num("vco period", 4 * m_n, n + 6);
		repeat (6) tick();
		check_bit("lock_flag_out", 1'b1, lock_flag_out);
		load({2'h0, 13'(m_r), 1'b0, 2'h0, 2'h3});
		check_bit("lock_flag_out", 1'(m_en), lock_flag_out);
		final_report();
	end

endmodule : test_pll_synth_divider_core

`default_nettype wire
